/* File: rtl/hv_latch_pkg.sv */
// Constants and types shared by the serial latch design
package hv_latch_pkg;
    localparam int WORD_W = 24;
    localparam int OUT_N = 21;
    localparam int OUT_N_BOOST = 19;
    localparam int SS_W = 15;
    // Boost PWM cycles spent in soft start
    localparam int SOFT_START_PWM_CYCLES = 16384;

    // Word layout, both kinds
    localparam int SEL_BIT = 0;
    // Setup word fields
    localparam int LEVEL_LSB = 1;
    localparam int LEVEL_MSB = 3;
    localparam int ILIM_LSB = 4;
    localparam int ILIM_MSB = 5;
    localparam int SS_OFF_BIT = 6;
    localparam int SYNC_BIT = 7;
    localparam int ILIM_OFF_BIT = 8;
    localparam int SETUP_MSB = 8;
    // Output word fields
    localparam int OUTS_LSB = 1;
    localparam int OUTS_MSB = 21;

    localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;
    localparam logic [WORD_W-1:0] SETUP_MASK = 24'h0001FE;
    localparam logic [WORD_W-1:0] OUT_MASK_FULL = 24'h3FFFFE;
    localparam logic [WORD_W-1:0] OUT_MASK_BOOST = 24'h0FFFFE;
    localparam logic [2:0] LEVEL_SHUTDOWN = 3'h0;
    localparam logic [1:0] ILIM_200MA = 2'h0;
    localparam logic [SS_W-1:0] SS_RESET = 15'h0000;

    typedef enum logic [1:0] {
        BOOST_SHUT = 2'b00,
        BOOST_SOFT = 2'b01,
        BOOST_RUN = 2'b11,
        BOOST_HOLD = 2'b10
    } boost_state_t;
endpackage

/* File: rtl/hv_output_serial_latch.sv */
// Serial-loaded setup and output latches driving high-voltage outputs
// Operation
// - Gate input low forces every used output to ground.
// - Gate high: outputs stored as one drive boost level, others low.
// - Shutdown or soft start: gate ignored, all outputs high impedance.
// - Serial clock and data ignored while latch strobe is high.
// - Strobe rising edge copies shift register into the holding latch selected by bit 0.
// - After strobe falls, first serial clock fall clears shift register and takes a new bit.
// - 24-bit register shifts toward MSB; host sends MSB first.
// - Data sampled on each falling serial clock edge while strobe low.
// - Latched words kept until same kind relatched or reset.
// - Reset clears both latches and the shift register.
// - Bit 0 zero selects setup latch, one selects output latch.
// - Output word drives 21 outputs, or 19 on the boost variant.
// - Setup bit 8 set disables the current limit.
// - Setup bit 7 set releases regulator on next PWM rising edge.
// - Setup bit 6 set skips soft start, selected limit at once.
// - Setup bits 5..4 select limit: 200 mA, 600 mA, 1 A, 1.5 A.
// - Setup bits 3..1 select boost level; zero means shutdown.
// - Setup bits 23..9 have no effect and read zero.
// - Output word bits 21..1 set outputs 20..0; bits 23..22 read zero, and 21..20 too on the boost variant.
// - Soft start limits current to 200 mA for 16384 PWM cycles.
`timescale 1ns/1ns
module hv_output_serial_latch #(
    parameter bit BOOST_VARIANT = 1'b1,
    parameter int SOFT_START_CYCLES = hv_latch_pkg::SOFT_START_PWM_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic serial_din,
    input wire logic latch_strobe_n,
    input wire logic out_gate,
    input wire logic boost_pwm_in,
    input wire logic target_reached,
    output logic [hv_latch_pkg::OUT_N-1:0] hv_out,
    output logic [hv_latch_pkg::OUT_N-1:0] hv_out_oe_n,
    output logic switch_drive,
    output logic [1:0] current_limit_eff,
    output logic current_limit_on,
    output logic [2:0] boost_level_sel,
    output logic release_sync_en,
    output logic soft_start_off,
    output logic current_limit_off,
    output logic [1:0] current_limit_sel,
    output logic shutdown,
    output logic soft_start_busy,
    output logic [hv_latch_pkg::WORD_W-1:0] setup_word_rd,
    output logic [hv_latch_pkg::WORD_W-1:0] out_word_rd
);
    import hv_latch_pkg::*;

    localparam logic [SS_W-1:0] SS_LAST = SS_W'(SOFT_START_CYCLES - 1);
    localparam logic [WORD_W-1:0] OUT_MASK =
        BOOST_VARIANT ? OUT_MASK_BOOST : OUT_MASK_FULL;
    localparam int OUT_USED = BOOST_VARIANT ? OUT_N_BOOST : OUT_N;

    // Strobe edge domain: one toggle per completed frame
    logic frame_tog_ff;
    // Link domain
    logic [WORD_W-1:0] shift_ff;
    logic [WORD_W-1:0] nxt_shift;
    logic seen_tog_ff;
    logic link_rst_meta_ff;
    logic link_rst_ff;
    // System domain synchronisers
    logic strobe_meta_ff;
    logic strobe_sync_ff;
    logic strobe_prev_ff;
    logic gate_meta_ff;
    logic gate_sync_ff;
    logic pwm_meta_ff;
    logic pwm_sync_ff;
    logic pwm_prev_ff;
    logic reach_meta_ff;
    logic reach_sync_ff;
    // Holding latches and boost control
    logic [WORD_W-1:0] setup_ff;
    logic [WORD_W-1:0] outs_ff;
    logic [2:0] level_prev_ff;
    boost_state_t boost_ff;
    boost_state_t nxt_boost;
    logic [SS_W-1:0] ss_cnt_ff;
    logic [OUT_N-1:0] hv_out_ff;
    logic [OUT_N-1:0] hv_oe_n_ff;
    logic switch_ff;
    logic strobe_rise;
    logic pwm_rise;
    logic boost_en;
    logic enabled_now;

    // The toggle only changes while the strobe is high, so the link side
    // reads it while it stands still; cleared with reset so that the
    // first frame compares against a known value
    always_ff @(posedge latch_strobe_n or posedge rst) begin
        if (rst) begin
            frame_tog_ff <= 1'b0;
        end else begin
            frame_tog_ff <= ~frame_tog_ff;
        end
    end

    // Reset reaches the link side only while its clock runs, so the
    // host must keep clocking the link through reset
    always_ff @(posedge link_clk) begin
        link_rst_meta_ff <= rst;
        link_rst_ff <= link_rst_meta_ff;
    end

    // A frame whose toggle is not yet seen starts from an empty register
    always_comb begin
        nxt_shift = shift_ff;
        if (seen_tog_ff != frame_tog_ff) begin
            nxt_shift = {{(WORD_W-1){1'b0}}, serial_din};
        end else begin
            nxt_shift = {shift_ff[WORD_W-2:0], serial_din};
        end
    end

    always_ff @(negedge link_clk) begin
        if (link_rst_ff) begin
            shift_ff <= WORD_RESET;
        end else if (!latch_strobe_n) begin
            shift_ff <= nxt_shift;
        end
    end

    always_ff @(negedge link_clk) begin
        if (link_rst_ff) begin
            seen_tog_ff <= 1'b0;
        end else if (!latch_strobe_n) begin
            seen_tog_ff <= frame_tog_ff;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            strobe_meta_ff <= 1'b1;
            strobe_sync_ff <= 1'b1;
            strobe_prev_ff <= 1'b1;
        end else begin
            strobe_meta_ff <= latch_strobe_n;
            strobe_sync_ff <= strobe_meta_ff;
            strobe_prev_ff <= strobe_sync_ff;
        end
    end

    // Gate is a pin, so outputs follow it three cycles late
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gate_meta_ff <= 1'b0;
            gate_sync_ff <= 1'b0;
        end else begin
            gate_meta_ff <= out_gate;
            gate_sync_ff <= gate_meta_ff;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pwm_meta_ff <= 1'b0;
            pwm_sync_ff <= 1'b0;
            pwm_prev_ff <= 1'b0;
        end else begin
            pwm_meta_ff <= boost_pwm_in;
            pwm_sync_ff <= pwm_meta_ff;
            pwm_prev_ff <= pwm_sync_ff;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reach_meta_ff <= 1'b0;
            reach_sync_ff <= 1'b0;
        end else begin
            reach_meta_ff <= target_reached;
            reach_sync_ff <= reach_meta_ff;
        end
    end

    // Edge flops reset to the idle level so no false edge follows reset
    assign strobe_rise = strobe_sync_ff && !strobe_prev_ff;
    assign pwm_rise = pwm_sync_ff && !pwm_prev_ff;

    // Shift register is frozen while the strobe is high, so it is safe
    // to copy here; the host must hold the strobe high for a few cycles
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            setup_ff <= WORD_RESET;
        end else if (strobe_rise && !shift_ff[SEL_BIT]) begin
            setup_ff <= shift_ff & SETUP_MASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            outs_ff <= WORD_RESET;
        end else if (strobe_rise && shift_ff[SEL_BIT]) begin
            outs_ff <= shift_ff & OUT_MASK;
        end
    end

    assign setup_word_rd = setup_ff;
    assign out_word_rd = outs_ff;
    assign boost_level_sel = setup_ff[LEVEL_MSB:LEVEL_LSB];
    assign current_limit_sel = setup_ff[ILIM_MSB:ILIM_LSB];
    assign soft_start_off = setup_ff[SS_OFF_BIT];
    assign release_sync_en = setup_ff[SYNC_BIT];
    assign current_limit_off = setup_ff[ILIM_OFF_BIT];
    assign boost_en = boost_level_sel != LEVEL_SHUTDOWN;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            level_prev_ff <= LEVEL_SHUTDOWN;
        end else begin
            level_prev_ff <= boost_level_sel;
        end
    end

    // Only a change out of shutdown starts the boost afresh
    assign enabled_now = boost_en && (level_prev_ff == LEVEL_SHUTDOWN);

    // Boost sequencing; only the boost variant has a soft-start phase
    always_comb begin
        nxt_boost = boost_ff;
        case (boost_ff)
            BOOST_SHUT: begin
                if (enabled_now) begin
                    if (soft_start_off || !BOOST_VARIANT) begin
                        nxt_boost = BOOST_RUN;
                    end else begin
                        nxt_boost = BOOST_SOFT;
                    end
                end
            end
            BOOST_SOFT: begin
                if (soft_start_off) begin
                    nxt_boost = BOOST_RUN;
                end else if (pwm_rise && ss_cnt_ff == SS_LAST) begin
                    nxt_boost = BOOST_RUN;
                end
            end
            BOOST_RUN: begin
                if (reach_sync_ff) begin
                    nxt_boost = BOOST_HOLD;
                end
            end
            BOOST_HOLD: begin
                if (!reach_sync_ff) begin
                    nxt_boost = BOOST_RUN;
                end
            end
            default: begin
                nxt_boost = BOOST_SHUT;
            end
        endcase
        if (!boost_en) begin
            nxt_boost = BOOST_SHUT;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            boost_ff <= BOOST_SHUT;
        end else begin
            boost_ff <= nxt_boost;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ss_cnt_ff <= SS_RESET;
        end else if (boost_ff != BOOST_SOFT) begin
            ss_cnt_ff <= SS_RESET;
        end else if (pwm_rise) begin
            ss_cnt_ff <= ss_cnt_ff + 1'b1;
        end
    end

    assign shutdown = boost_ff == BOOST_SHUT;
    assign soft_start_busy = boost_ff == BOOST_SOFT;

    // Soft start overrides both the selection and the disable bit
    always_comb begin
        current_limit_eff = current_limit_sel;
        current_limit_on = !current_limit_off;
        if (soft_start_busy) begin
            current_limit_eff = ILIM_200MA;
            current_limit_on = 1'b1;
        end
    end

    // Synchronised release waits for a PWM rising edge, costing up to
    // one PWM period of overshoot; asynchronous release stops at once
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            switch_ff <= 1'b0;
        end else if (!BOOST_VARIANT || shutdown) begin
            switch_ff <= 1'b0;
        end else if (boost_ff == BOOST_HOLD) begin
            if (!release_sync_en || pwm_rise) begin
                switch_ff <= 1'b0;
            end else begin
                switch_ff <= pwm_sync_ff;
            end
        end else begin
            switch_ff <= pwm_sync_ff;
        end
    end

    assign switch_drive = switch_ff;

    // Pins beyond the used count stay released on the boost variant
    genvar gi;
    generate
        for (gi = 0; gi < OUT_N; gi++) begin : g_out
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    hv_out_ff[gi] <= 1'b0;
                    hv_oe_n_ff[gi] <= 1'b1;
                end else if (gi >= OUT_USED) begin
                    hv_out_ff[gi] <= 1'b0;
                    hv_oe_n_ff[gi] <= 1'b1;
                end else if (shutdown || soft_start_busy) begin
                    hv_out_ff[gi] <= 1'b0;
                    hv_oe_n_ff[gi] <= 1'b1;
                end else if (!gate_sync_ff) begin
                    hv_out_ff[gi] <= 1'b0;
                    hv_oe_n_ff[gi] <= 1'b0;
                end else begin
                    hv_out_ff[gi] <= outs_ff[OUTS_LSB + gi];
                    hv_oe_n_ff[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign hv_out = hv_out_ff;
    assign hv_out_oe_n = hv_oe_n_ff;
endmodule

/* File: test/hv_latch_checker.sv */
// Port assertions for the serial output latch
`timescale 1ns/1ns
module hv_latch_checker #(
    parameter bit BOOST_VARIANT = 1'b1,
    parameter int SOFT_START_CYCLES = 16384
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic latch_strobe_n,
    input wire logic out_gate,
    input wire logic [hv_latch_pkg::OUT_N-1:0] hv_out,
    input wire logic [hv_latch_pkg::OUT_N-1:0] hv_out_oe_n,
    input wire logic switch_drive,
    input wire logic [1:0] current_limit_eff,
    input wire logic current_limit_on,
    input wire logic [2:0] boost_level_sel,
    input wire logic release_sync_en,
    input wire logic soft_start_off,
    input wire logic current_limit_off,
    input wire logic [1:0] current_limit_sel,
    input wire logic shutdown,
    input wire logic soft_start_busy,
    input wire logic [hv_latch_pkg::WORD_W-1:0] setup_word_rd,
    input wire logic [hv_latch_pkg::WORD_W-1:0] out_word_rd
);
    import hv_latch_pkg::*;
    localparam logic [20:0] IMPL = BOOST_VARIANT ? 21'h07FFFF : 21'h1FFFFF;
    localparam logic [23:0] OMASK = BOOST_VARIANT ? OUT_MASK_BOOST :
        OUT_MASK_FULL;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // Depth 3 covers the state register plus the output register
    sequence quiet_s;
        (shutdown || soft_start_busy)[*3];
    endsequence
    sequence gate_low_s;
        (!out_gate && !shutdown && !soft_start_busy)[*5];
    endsequence
    sequence gate_high_s;
        (out_gate && !shutdown && !soft_start_busy
            && $stable(out_word_rd))[*5];
    endsequence
    setup_mask_a: assert property (
        (setup_word_rd & ~SETUP_MASK) == 24'h0)
        else $error("setup word has unimplemented bits set");
    out_mask_a: assert property ((out_word_rd & ~OMASK) == 24'h0)
        else $error("output word has unimplemented bits set");
    level_field_a: assert property (
        boost_level_sel == setup_word_rd[3:1])
        else $error("boost level field mismatch");
    option_fields_a: assert property (
        {current_limit_off, release_sync_en,
        soft_start_off, current_limit_sel} == setup_word_rd[8:4])
        else $error("setup option fields mismatch");
    hiz_outputs_a: assert property (quiet_s |-> &hv_out_oe_n)
        else $error("outputs driven in shutdown or soft start");
    gate_low_a: assert property (gate_low_s |-> hv_out == 21'h0
        && (hv_out_oe_n & IMPL) == 21'h0)
        else $error("gate low did not ground outputs");
    gate_high_a: assert property (gate_high_s |->
        (hv_out & IMPL) == (out_word_rd[21:1] & IMPL))
        else $error("gate high outputs differ from stored levels");
    hold_latches_a: assert property (latch_strobe_n[*7] |->
        $stable(setup_word_rd) && $stable(out_word_rd))
        else $error("latch changed while strobe idle");
    unused_pins_a: assert property (
        !BOOST_VARIANT || &hv_out_oe_n[20:19])
        else $error("unimplemented output driven");
    limit_soft_a: assert property (soft_start_busy |->
        current_limit_eff == ILIM_200MA && current_limit_on)
        else $error("soft start limit not forced");
    limit_sel_a: assert property (!soft_start_busy |->
        current_limit_eff == current_limit_sel
        && current_limit_on == !current_limit_off)
        else $error("selected current limit not applied");
    switch_off_a: assert property (shutdown |=> !switch_drive)
        else $error("boost switch active in shutdown");
endmodule
bind hv_output_serial_latch hv_latch_checker #(
    .BOOST_VARIANT(BOOST_VARIANT),
    .SOFT_START_CYCLES(SOFT_START_CYCLES)
) chk (.clk_sys(clk_sys), .rst(rst), .latch_strobe_n(latch_strobe_n),
    .out_gate(out_gate), .hv_out(hv_out), .hv_out_oe_n(hv_out_oe_n),
    .switch_drive(switch_drive), .current_limit_eff(current_limit_eff),
    .current_limit_on(current_limit_on),
    .boost_level_sel(boost_level_sel), .release_sync_en(release_sync_en),
    .soft_start_off(soft_start_off), .current_limit_off(current_limit_off),
    .current_limit_sel(current_limit_sel), .shutdown(shutdown),
    .soft_start_busy(soft_start_busy), .setup_word_rd(setup_word_rd),
    .out_word_rd(out_word_rd));

/* File: test/host_model.sv */
// Host model driving the three-wire serial link
`timescale 1ns/1ns
module host_model (
    output logic link_clk,
    output logic serial_din,
    output logic latch_strobe_n
);
    initial begin
        link_clk = 1'b1;
        serial_din = 1'b0;
        latch_strobe_n = 1'b1;
    end
    // Data moves only while the clock is high, so falls see it settled
    task automatic shift(input logic b);
        serial_din = b;
        #24 link_clk = 1'b0;
        #24 link_clk = 1'b1;
    endtask
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            shift(i[0]);
        end
    endtask
    task automatic send(input logic [3:0] pre, input bit extra,
        input logic [23:0] w);
        latch_strobe_n = 1'b0;
        #24;
        if (extra) begin
            for (int i = 3; i >= 0; i--) shift(pre[i]);
        end
        for (int i = 23; i >= 0; i--) begin
            shift(w[i]);
        end
        #24 latch_strobe_n = 1'b1;
        // Released line does not keep the last bit
        serial_din = ~serial_din;
    endtask
    // Frame shorter than a word: leading bits come from the clear
    task automatic send_short(input int n, input logic [23:0] w);
        latch_strobe_n = 1'b0;
        #24;
        for (int i = n - 1; i >= 0; i--) begin
            shift(w[i]);
        end
        #24 latch_strobe_n = 1'b1;
        serial_din = ~serial_din;
    endtask
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the serial output latch
`timescale 1ns/1ns
module tb_top;
    import hv_latch_pkg::*;
    typedef struct {logic [23:0] w; logic [23:0] s; logic [23:0] o;} row_t;
    logic clk_sys, rst, out_gate, boost_pwm_in, target_reached;
    logic link_clk, serial_din, latch_strobe_n, shutdown, soft_start_busy;
    logic switch_drive;
    logic [20:0] hv_out, hv_out_oe_n;
    logic [23:0] setup_word_rd, out_word_rd;
    int miscompares = 0;
    int n_compared = 0;
    row_t rows [4] = '{'{24'hFFFE4E, 24'h00004E, 24'h000000},
        '{24'hFFFFFF, 24'h00004E, 24'h0FFFFE},
        '{24'h0A5A5B, 24'h00004E, 24'h0A5A5A},
        '{24'h000130, 24'h000130, 24'h0A5A5A}};
    host_model host (.link_clk(link_clk), .serial_din(serial_din),
        .latch_strobe_n(latch_strobe_n));
    hv_output_serial_latch #(.BOOST_VARIANT(1'b1), .SOFT_START_CYCLES(8))
    DUT (.clk_sys(clk_sys), .rst(rst), .link_clk(link_clk),
        .serial_din(serial_din), .latch_strobe_n(latch_strobe_n),
        .out_gate(out_gate), .boost_pwm_in(boost_pwm_in),
        .target_reached(target_reached), .hv_out(hv_out),
        .hv_out_oe_n(hv_out_oe_n), .switch_drive(switch_drive),
        .current_limit_eff(),
        .current_limit_on(), .boost_level_sel(), .release_sync_en(),
        .soft_start_off(), .current_limit_off(), .current_limit_sel(),
        .shutdown(shutdown), .soft_start_busy(soft_start_busy),
        .setup_word_rd(setup_word_rd), .out_word_rd(out_word_rd));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic check(input string what, input logic [23:0] seen,
        input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Boost variant: pins 19 and 20 never driven
    task automatic chk_pins(input bit hz, input logic [23:0] o);
        logic [20:0] hv;
        logic [20:0] oe;
        hv = out_gate ? {2'b00, o[19:1]} : 21'h0;
        oe = hz ? 21'h1FFFFF : 21'h180000;
        check("oe_n", 24'(hv_out_oe_n), 24'(oe));
        if (!hz) check("hv_out", 24'(hv_out & 21'h07FFFF), 24'(hv));
    endtask
    task automatic pwm(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            boost_pwm_in <= 1'b1;
            repeat (3) @(posedge clk_sys);
            boost_pwm_in <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
        wait_cyc(4);
    endtask
    task automatic do_reset;
        @(posedge clk_sys);
        rst <= 1'b1;
        // Link side only leaves reset on running link clock edges
        fork
            host.idle_clocks(12);
            begin
                repeat (8) @(posedge clk_sys);
                rst <= 1'b0;
            end
        join
        wait_cyc(2);
        check("setup", setup_word_rd, 24'h0);
        check("out", out_word_rd, 24'h0);
        chk_pins(1'b1, 24'h0);
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        out_gate = 1'b1;
        boost_pwm_in = 1'b0;
        target_reached = 1'b0;
        do_reset();
        for (int i = 0; i < 4; i++) begin
            host.send(4'h0, 1'b0, rows[i].w);
            wait_cyc(8);
            check("setup", setup_word_rd, rows[i].s);
            check("out", out_word_rd, rows[i].o);
            chk_pins(rows[i].s[3:1] == 3'h0, rows[i].o);
            $display("row %0d done", i);
        end
        host.idle_clocks(30);
        wait_cyc(8);
        check("idle setup", setup_word_rd, 24'h000130);
        check("idle out", out_word_rd, 24'h0A5A5A);
        $display("strobe high test done");
        // Extra leading bits must fall off the top
        host.send(4'hF, 1'b1, 24'h00000C);
        wait_cyc(8);
        check("long frame", setup_word_rd, 24'h00000C);
        check("soft start", 24'(soft_start_busy), 24'h1);
        chk_pins(1'b1, 24'h0A5A5A);
        pwm(7);
        check("soft start 7", 24'(soft_start_busy), 24'h1);
        pwm(1);
        check("soft start 8", 24'(soft_start_busy), 24'h0);
        chk_pins(1'b0, 24'h0A5A5A);
        $display("soft start test done");
        @(posedge clk_sys);
        target_reached <= 1'b1;
        boost_pwm_in <= 1'b1;
        wait_cyc(6);
        check("release", 24'(switch_drive), 24'h0);
        @(posedge clk_sys);
        target_reached <= 1'b0;
        wait_cyc(6);
        check("switch run", 24'(switch_drive), 24'h1);
        @(posedge clk_sys);
        boost_pwm_in <= 1'b0;
        wait_cyc(4);
        $display("release test done");
        @(posedge clk_sys);
        out_gate <= 1'b0;
        wait_cyc(6);
        chk_pins(1'b0, 24'h0A5A5A);
        out_gate <= 1'b1;
        wait_cyc(6);
        chk_pins(1'b0, 24'h0A5A5A);
        $display("gate test done");
        // Upper bits of the previous frame must not survive
        host.send_short(12, 24'h000131);
        wait_cyc(8);
        check("short frame", out_word_rd, 24'h000130);
        chk_pins(1'b0, 24'h000130);
        $display("short frame test done");
        do_reset();
        $display("reset test done");
        tally_and_finish();
    end
    initial begin
        #100000;
        miscompares++;
        tally_and_finish();
    end
endmodule
